// File: sbc_pkg.sv
// constants and types shared by the standby controller and its cpu end
package sbc_pkg;
  // register addresses on the device access port
  localparam logic [15:0] SBC_ADDR_MOC    = 16'hFFA1;
  localparam logic [15:0] SBC_ADDR_STATUS = 16'hFFA3;
  localparam logic [15:0] SBC_ADDR_SELECT = 16'hFFA4;
  localparam logic [7:0]  SBC_STATUS_RST  = 8'h00;
  localparam logic [7:0]  SBC_SELECT_RST  = 8'h05;
  localparam logic [7:0]  SBC_MOC_RST     = 8'h00;
  localparam int          SBC_MOC_STOP_BIT = 7;
  localparam int          SBC_SEL_W       = 3;
  localparam int          SBC_CNT_W       = 17;
  localparam int          SBC_NSTAT       = 5;
  // crystal cycle exponents, status bit 4 down to bit 0
  localparam int          SBC_EXP [5]     = '{11, 13, 14, 15, 16};
  localparam int          SBC_EXP_MAX     = 16;
  // resume delays in cpu clocks
  localparam logic [3:0]  SBC_WAKE_VEC    = 4'h8;
  localparam logic [3:0]  SBC_WAKE_NEXT   = 4'h2;
  // crystal rate derived from the bus clock
  localparam int          SBC_HCLK_KHZ    = 250000;
  localparam int          SBC_XTAL_KHZ    = 10000;
  localparam int          SBC_XTAL_DIV    = SBC_HCLK_KHZ / SBC_XTAL_KHZ;
  // cpu end register offsets and fields
  localparam logic [7:0]  SBC_HOFS_CTRL   = 8'h00;
  localparam logic [7:0]  SBC_HOFS_ACC    = 8'h04;
  localparam logic [7:0]  SBC_HOFS_STAT   = 8'h08;
  localparam int          SBC_CTRL_HALT   = 0;
  localparam int          SBC_CTRL_STOP   = 1;
  localparam int          SBC_CTRL_SRC    = 2;
  localparam int          SBC_CTRL_IE     = 4;
  localparam int          SBC_ACC_WDATA   = 16;
  localparam int          SBC_ACC_WR      = 24;
  localparam int          SBC_ACC_BITOP   = 25;
  localparam int          SBC_ACC_BUSY    = 8;

  typedef enum logic [1:0] {
    SBC_SRC_IHS  = 2'b00,
    SBC_SRC_XTAL = 2'b01,
    SBC_SRC_SUB  = 2'b10,
    SBC_SRC_EXT  = 2'b11
  } sbc_src_t;

  typedef enum logic [2:0] {
    SBC_RUN  = 3'b000,
    SBC_HALT = 3'b001,
    SBC_STOP = 3'b010,
    SBC_STAB = 3'b011,
    SBC_WAKE = 3'b100
  } sbc_mode_t;
endpackage : sbc_pkg

// File: sbc_if.sv
// link between the cpu core end and the standby controller
interface sbc_if;
  logic                 cmd_halt;
  logic                 cmd_stop;
  logic                 irq_req;
  logic                 int_enable;
  sbc_pkg::sbc_src_t    cpu_src;
  logic [15:0]          reg_addr;
  logic                 reg_rd;
  logic                 reg_wr;
  logic                 reg_bitop;
  logic [7:0]           reg_wdata;
  logic [7:0]           reg_rdata;
  logic                 reg_ack;
  logic                 cpu_clk_en;
  logic                 resume;
  logic                 resume_vec;
  logic                 stab_busy;
  logic                 refused;

  modport dev (
    input  cmd_halt, cmd_stop, irq_req, int_enable, cpu_src,
    input  reg_addr, reg_rd, reg_wr, reg_bitop, reg_wdata,
    output reg_rdata, reg_ack, cpu_clk_en, resume, resume_vec,
    output stab_busy, refused
  );
  modport cpu (
    output cmd_halt, cmd_stop, irq_req, int_enable, cpu_src,
    output reg_addr, reg_rd, reg_wr, reg_bitop, reg_wdata,
    input  reg_rdata, reg_ack, cpu_clk_en, resume, resume_vec,
    input  stab_busy, refused
  );
endinterface : sbc_if

// File: sbc_standby_ctl.sv
// standby controller: halt, stop and crystal stabilization wait
//
// Local design decision: the AHB-Lite slave port.

// Notes on behaviour
// - halt gates cpu clock, oscillators keep running
// - stop halts crystal and internal fast oscillator
// - interrupt ends stop; crystal source waits first
// - standby keeps all cpu state untouched
// - stop only from main clock; halt always
// - subsystem oscillator never stopped
// - software idles main-clock peripherals before stop
// - read-only status shows counter progress
// - status cleared by reset, stop, crystal stop
// - sticky status bits at 2^11..2^16 cycles
// - after stop, counter stops at selection
// - crystal cpu waits selected length after stop
// - select codes 1..5 map to wait lengths
// - select byte-written, resets 05h, upper zero
// - software polls status on internal fast clock
// - select set before stop, not during wait
// - wait counts only once crystal oscillates
// - halt exit: 8 clocks vectored, else 2
// - reset ends halt like normal reset
module sbc_standby_ctl #(
  parameter int XTAL_DIV = sbc_pkg::SBC_XTAL_DIV
) (
  input  wire logic hclk,
  input  wire logic hresetn,
  sbc_if.dev        link,
  input  wire logic xtal_running,
  output logic      main_osc_en,
  output logic      int_hs_osc_en,
  output logic      sub_osc_en
);
  localparam int DIV_W = (XTAL_DIV > 1) ? $clog2(XTAL_DIV) : 1;
  localparam int CW    = sbc_pkg::SBC_CNT_W;

  sbc_pkg::sbc_mode_t  mode_q;
  logic [DIV_W-1:0]    div_q;
  logic                tick_q;
  logic [CW-1:0]       cnt_q;
  logic                cap_q;
  logic [sbc_pkg::SBC_SEL_W-1:0] sel_q;
  logic [7:0]          moc_q;
  logic [sbc_pkg::SBC_NSTAT-1:0] stat_q;
  logic [3:0]          wake_q;
  logic                clr_stat;
  logic                stop_ok;
  logic                moc_wr;
  logic [CW-1:0]       sel_limit;
  logic [CW-1:0]       limit;
  logic                cnt_en;

  // wait length for a select code; prohibited codes fall back to longest
  function automatic logic [CW-1:0] sel_thr(
    input logic [sbc_pkg::SBC_SEL_W-1:0] code
  );
    logic [CW-1:0] one;
    one = {{(CW-1){1'b0}}, 1'b1};
    case (code)
      3'h1:    sel_thr = one << sbc_pkg::SBC_EXP[0];
      3'h2:    sel_thr = one << sbc_pkg::SBC_EXP[1];
      3'h3:    sel_thr = one << sbc_pkg::SBC_EXP[2];
      3'h4:    sel_thr = one << sbc_pkg::SBC_EXP[3];
      default: sel_thr = one << sbc_pkg::SBC_EXP[4];
    endcase
  endfunction : sel_thr

  // stop is honoured only off the subsystem clock
  assign stop_ok = link.cmd_stop &&
                   (link.cpu_src != sbc_pkg::SBC_SRC_SUB);
  assign moc_wr  = link.reg_wr && (link.reg_addr == sbc_pkg::SBC_ADDR_MOC);
  // clearing events: accepted stop, or crystal stop bit written to one
  assign clr_stat = (mode_q == sbc_pkg::SBC_RUN && stop_ok) ||
                    (moc_wr &&
                     link.reg_wdata[sbc_pkg::SBC_MOC_STOP_BIT]);
  assign sel_limit = sel_thr(sel_q);
  // after a stop the count saturates at the selection, else at 2^16
  assign limit  = cap_q ? sel_limit
                        : ({{(CW-1){1'b0}}, 1'b1} << sbc_pkg::SBC_EXP_MAX);
  // counts only crystal cycles that really oscillate
  assign cnt_en = tick_q && xtal_running && main_osc_en &&
                  (cnt_q < limit);

  // crystal rate enable, one pulse per crystal cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_q  <= '0;
      tick_q <= 1'b0;
    end else if (div_q == DIV_W'(XTAL_DIV - 1)) begin
      div_q  <= '0;
      tick_q <= 1'b1;
    end else begin
      div_q  <= div_q + 1'b1;
      tick_q <= 1'b0;
    end
  end

  // stabilization up-counter, cleared by the same events as status
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= '0;
      cap_q <= 1'b0;
    end else if (clr_stat) begin
      cnt_q <= '0;
      cap_q <= (mode_q == sbc_pkg::SBC_RUN) && stop_ok;
    end else if (cnt_en) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  // sticky progress bits; the counter restarts with them, so its old count must not set them again
  for (genvar b = 0; b < sbc_pkg::SBC_NSTAT; b++) begin : g_stat
    localparam logic [CW-1:0] THR =
      {{(CW-1){1'b0}}, 1'b1} << sbc_pkg::SBC_EXP[sbc_pkg::SBC_NSTAT-1-b];
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        stat_q[b] <= 1'b0;
      end else begin
        stat_q[b] <= (stat_q[b] || cnt_q >= THR) && !clr_stat;
      end
    end
  end

  // select register: byte writes only, upper bits stay zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sel_q <= sbc_pkg::SBC_SELECT_RST[sbc_pkg::SBC_SEL_W-1:0];
    end else if (link.reg_wr && !link.reg_bitop &&
                 link.reg_addr == sbc_pkg::SBC_ADDR_SELECT) begin
      sel_q <= link.reg_wdata[sbc_pkg::SBC_SEL_W-1:0];
    end
  end

  // crystal oscillator control byte, bit or byte writes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      moc_q <= sbc_pkg::SBC_MOC_RST;
    end else if (moc_wr) begin
      moc_q <= link.reg_wdata;
    end
  end

  // register read port: answer one cycle after the strobe
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      link.reg_ack   <= 1'b0;
      link.reg_rdata <= 8'h00;
    end else begin
      link.reg_ack <= link.reg_rd || link.reg_wr;
      if (link.reg_rd) begin
        case (link.reg_addr)
          sbc_pkg::SBC_ADDR_STATUS:
            link.reg_rdata <= {3'h0, stat_q};
          sbc_pkg::SBC_ADDR_SELECT:
            link.reg_rdata <= {5'h00, sel_q};
          sbc_pkg::SBC_ADDR_MOC:
            link.reg_rdata <= moc_q;
          default:
            link.reg_rdata <= 8'h00;
        endcase
      end
    end
  end

  // standby sequencer; reset always returns to run with clock on
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_q          <= sbc_pkg::SBC_RUN;
      link.cpu_clk_en <= 1'b1;
      link.resume     <= 1'b0;
      link.resume_vec <= 1'b0;
      link.refused    <= 1'b0;
      wake_q          <= 4'h0;
    end else begin
      link.resume  <= 1'b0;
      link.refused <= 1'b0;
      case (mode_q)
        sbc_pkg::SBC_RUN: begin
          if (link.cmd_halt) begin
            mode_q          <= sbc_pkg::SBC_HALT;
            link.cpu_clk_en <= 1'b0;
          end else if (stop_ok) begin
            mode_q          <= sbc_pkg::SBC_STOP;
            link.cpu_clk_en <= 1'b0;
          end else if (link.cmd_stop) begin
            link.refused <= 1'b1;
          end
        end
        sbc_pkg::SBC_HALT: begin
          if (link.irq_req) begin
            mode_q <= sbc_pkg::SBC_WAKE;
            wake_q <= link.int_enable ? sbc_pkg::SBC_WAKE_VEC
                                      : sbc_pkg::SBC_WAKE_NEXT;
            link.resume_vec <= link.int_enable;
          end
        end
        sbc_pkg::SBC_STOP: begin
          // a pending request ends stop at once; a crystal source enters the wait first, others wake as a halt would
          if (link.irq_req) begin
            link.resume_vec <= link.int_enable;
            if (link.cpu_src == sbc_pkg::SBC_SRC_XTAL) begin
              mode_q <= sbc_pkg::SBC_STAB;
            end else begin
              mode_q <= sbc_pkg::SBC_WAKE;
              wake_q <= link.int_enable ? sbc_pkg::SBC_WAKE_VEC
                                        : sbc_pkg::SBC_WAKE_NEXT;
            end
          end
        end
        sbc_pkg::SBC_STAB: begin
          // hold the cpu until the selected crystal count is reached
          if (cnt_q >= sel_limit) begin
            mode_q <= sbc_pkg::SBC_WAKE;
            wake_q <= link.resume_vec ? sbc_pkg::SBC_WAKE_VEC
                                      : sbc_pkg::SBC_WAKE_NEXT;
          end
        end
        sbc_pkg::SBC_WAKE: begin
          if (wake_q <= 4'h1) begin
            mode_q          <= sbc_pkg::SBC_RUN;
            link.cpu_clk_en <= 1'b1;
            link.resume     <= 1'b1;
          end else begin
            wake_q <= wake_q - 1'b1;
          end
        end
        default: begin
          mode_q          <= sbc_pkg::SBC_RUN;
          link.cpu_clk_en <= 1'b1;
        end
      endcase
    end
  end

  // oscillator enables; the subsystem one is never switched off
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      main_osc_en    <= 1'b1;
      int_hs_osc_en  <= 1'b1;
      sub_osc_en     <= 1'b1;
      link.stab_busy <= 1'b0;
    end else begin
      main_osc_en    <= (mode_q != sbc_pkg::SBC_STOP) &&
                        !moc_q[sbc_pkg::SBC_MOC_STOP_BIT];
      int_hs_osc_en  <= (mode_q != sbc_pkg::SBC_STOP);
      sub_osc_en     <= 1'b1;
      link.stab_busy <= (mode_q == sbc_pkg::SBC_STAB);
    end
  end
endmodule : sbc_standby_ctl

// File: sbc_cpu_end.sv
// cpu core end: ahb-lite command registers driving the standby link
module sbc_cpu_end (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        irq_in,
  input  wire logic        periph_main_busy,
  sbc_if.cpu               link
);
  logic        wr_pend_q;
  logic [7:0]  wofs_q;
  logic        busy_q;
  logic [7:0]  rdata_q;
  logic        refused_q;
  logic        resumed_q;
  logic        ie_q;
  logic [1:0]  src_q;
  logic        take;
  logic [7:0]  aofs;
  logic [31:0] rd_val;
  logic        want_stop;
  logic        sel_wr;

  assign take = hsel && htrans[1] && hready;
  assign aofs = haddr[7:0];
  assign want_stop = wr_pend_q && wofs_q == sbc_pkg::SBC_HOFS_CTRL &&
                     hwdata[sbc_pkg::SBC_CTRL_STOP];
  assign sel_wr = hwdata[15:0] == sbc_pkg::SBC_ADDR_SELECT &&
                  hwdata[sbc_pkg::SBC_ACC_WR];

  // read mux, unmapped offsets read zero
  always_comb begin
    rd_val = 32'h0000_0000;
    case (aofs)
      sbc_pkg::SBC_HOFS_CTRL:
        rd_val = {27'h0, ie_q, src_q, 2'h0};
      sbc_pkg::SBC_HOFS_ACC:
        rd_val = {23'h0, busy_q, rdata_q};
      sbc_pkg::SBC_HOFS_STAT:
        rd_val = {27'h0, link.resume_vec, resumed_q, refused_q,
                  link.stab_busy, link.cpu_clk_en};
      default: rd_val = 32'h0000_0000;
    endcase
  end

  // bus slave: zero wait, always okay, read data set in address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wofs_q    <= 8'h00;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      wr_pend_q <= take && hwrite;
      if (take) begin
        wofs_q <= aofs;
      end
      if (take && !hwrite) begin
        hrdata <= rd_val;
      end
    end
  end

  // standby commands, clock source and interrupt enable
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      link.cmd_halt   <= 1'b0;
      link.cmd_stop   <= 1'b0;
      link.int_enable <= 1'b0;
      link.cpu_src    <= sbc_pkg::SBC_SRC_IHS;
      link.irq_req    <= 1'b0;
      ie_q            <= 1'b0;
      src_q           <= 2'h0;
    end else begin
      link.irq_req    <= irq_in;
      link.cmd_halt   <= 1'b0;
      link.cmd_stop   <= 1'b0;
      link.int_enable <= ie_q;
      link.cpu_src    <= sbc_pkg::sbc_src_t'(src_q);
      if (wr_pend_q && wofs_q == sbc_pkg::SBC_HOFS_CTRL) begin
        ie_q  <= hwdata[sbc_pkg::SBC_CTRL_IE];
        src_q <= hwdata[sbc_pkg::SBC_CTRL_SRC +: 2];
        link.cmd_halt <= hwdata[sbc_pkg::SBC_CTRL_HALT];
        // stop only from main clock with its peripherals idle
        link.cmd_stop <= want_stop && !hwdata[sbc_pkg::SBC_CTRL_HALT] &&
                         src_q != 2'(sbc_pkg::SBC_SRC_SUB) &&
                         !periph_main_busy;
      end
    end
  end

  // device register access; select writes are refused while stab_busy is set
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      link.reg_rd    <= 1'b0;
      link.reg_wr    <= 1'b0;
      link.reg_addr  <= 16'h0000;
      link.reg_wdata <= 8'h00;
      link.reg_bitop <= 1'b0;
      busy_q         <= 1'b0;
      rdata_q        <= 8'h00;
    end else begin
      link.reg_rd <= 1'b0;
      link.reg_wr <= 1'b0;
      if (link.reg_ack) begin
        busy_q  <= 1'b0;
        rdata_q <= link.reg_rdata;
      end
      if (wr_pend_q && wofs_q == sbc_pkg::SBC_HOFS_ACC && !busy_q &&
          !(sel_wr && link.stab_busy)) begin
        busy_q         <= 1'b1;
        link.reg_addr  <= hwdata[15:0];
        link.reg_wdata <= hwdata[sbc_pkg::SBC_ACC_WDATA +: 8];
        link.reg_bitop <= hwdata[sbc_pkg::SBC_ACC_BITOP];
        link.reg_wr    <= hwdata[sbc_pkg::SBC_ACC_WR];
        link.reg_rd    <= !hwdata[sbc_pkg::SBC_ACC_WR];
      end
    end
  end

  // sticky flags; a new event wins over the clearing write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      refused_q <= 1'b0;
      resumed_q <= 1'b0;
    end else begin
      refused_q <= link.refused ||
                   (want_stop && (src_q == 2'(sbc_pkg::SBC_SRC_SUB) ||
                                  periph_main_busy)) ||
                   (wr_pend_q && wofs_q == sbc_pkg::SBC_HOFS_ACC &&
                    sel_wr && link.stab_busy) ||
                   (refused_q && !(wr_pend_q &&
                                   wofs_q == sbc_pkg::SBC_HOFS_STAT));
      resumed_q <= link.resume ||
                   (resumed_q && !(wr_pend_q &&
                                   wofs_q == sbc_pkg::SBC_HOFS_STAT));
    end
  end
endmodule : sbc_cpu_end

// File: sbc_link_chk.sv
// assertions on the standby link between the cpu end and the controller
module sbc_link_chk (
  input wire logic              hclk,
  input wire logic              hresetn,
  input wire logic              cmd_halt,
  input wire logic              cmd_stop,
  input wire logic              irq_req,
  input wire logic              int_enable,
  input wire sbc_pkg::sbc_src_t cpu_src,
  input wire logic [15:0]       reg_addr,
  input wire logic              reg_rd,
  input wire logic              reg_wr,
  input wire logic [7:0]        reg_rdata,
  input wire logic              reg_ack,
  input wire logic              cpu_clk_en,
  input wire logic              resume,
  input wire logic              stab_busy,
  input wire logic              xtal_running,
  input wire logic              main_osc_en,
  input wire logic              int_hs_osc_en,
  input wire logic              sub_osc_en
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // plain wake only: a crystal stop goes through the wait first
  wire wake_ok = !cpu_clk_en && !stab_busy
                 && (cpu_src != sbc_pkg::SBC_SRC_XTAL || main_osc_en);

  a_halt_gates_clk: assert property (cmd_halt && cpu_clk_en |=> !cpu_clk_en)
    else $error("halt left the cpu clock running");
  a_stop_osc_off: assert property (cmd_stop && !cmd_halt && cpu_clk_en && !irq_req
    && cpu_src != sbc_pkg::SBC_SRC_SUB |=> !cpu_clk_en ##1 (!main_osc_en && !int_hs_osc_en))
    else $error("stop left a fast oscillator on");
  a_sub_osc_on: assert property (sub_osc_en)
    else $error("subsystem oscillator stopped");
  a_no_stop_sub: assert property (cpu_src == sbc_pkg::SBC_SRC_SUB |-> !cmd_stop)
    else $error("stop issued on subsystem clock");
  // the first stop cycle still shows the crystal on, so the clock must have been off before
  a_wake_vec_delay: assert property ($rose(irq_req) && wake_ok && int_enable
    && !$past(cpu_clk_en) |-> !resume [*8] ##[1:4] resume)
    else $error("vectored wake delay wrong");
  a_wake_next_delay: assert property ($rose(irq_req) && wake_ok && !int_enable
    && !$past(cpu_clk_en) |-> !resume [*2] ##[1:4] resume)
    else $error("plain wake delay wrong");
  a_ack_follows: assert property ((reg_rd || reg_wr) |=> reg_ack)
    else $error("register access not acknowledged");
  a_status_form: assert property (reg_ack && $past(reg_rd)
    && $past(reg_addr) == sbc_pkg::SBC_ADDR_STATUS
    |-> reg_rdata inside {8'h00, 8'h10, 8'h18, 8'h1C, 8'h1E, 8'h1F})
    else $error("status bits out of order");
  a_select_upper: assert property (reg_ack && $past(reg_rd)
    && $past(reg_addr) == sbc_pkg::SBC_ADDR_SELECT |-> reg_rdata[7:3] == 5'h00)
    else $error("select upper bits not zero");
  a_stab_gates_clk: assert property (stab_busy |-> !cpu_clk_en)
    else $error("cpu ran during the wait");
  a_stab_needs_xtal: assert property (!xtal_running [*3] ##0 stab_busy |=> stab_busy)
    else $error("wait ended without oscillation");

  c_halt: cover property (cmd_halt);
  c_stop: cover property (cmd_stop);
  c_wait_end: cover property ($fell(stab_busy));
endmodule : sbc_link_chk

// File: tb_top.sv
// self-checking bench: cpu end and standby controller joined by the link
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        irq_in;
  logic        periph_main_busy;
  logic        xtal_running;
  logic        main_osc_en;
  logic        int_hs_osc_en;
  logic        sub_osc_en;
  logic [31:0] rd;
  int          errors;
  int          n_tests;
  int          n;

  sbc_if link ();
  // divider of 1 keeps the longest wait near 65k cycles
  sbc_standby_ctl #(.XTAL_DIV(1)) sbc_standby_ctl_i (.hclk(hclk), .hresetn(hresetn),
    .link(link), .xtal_running(xtal_running), .main_osc_en(main_osc_en),
    .int_hs_osc_en(int_hs_osc_en), .sub_osc_en(sub_osc_en));
  sbc_cpu_end sbc_cpu_end_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq_in(irq_in),
    .periph_main_busy(periph_main_busy), .link(link));
  sbc_link_chk chk_i (.hclk(hclk), .hresetn(hresetn), .cmd_halt(link.cmd_halt),
    .cmd_stop(link.cmd_stop), .irq_req(link.irq_req), .int_enable(link.int_enable),
    .cpu_src(link.cpu_src), .reg_addr(link.reg_addr), .reg_rd(link.reg_rd),
    .reg_wr(link.reg_wr), .reg_rdata(link.reg_rdata), .reg_ack(link.reg_ack),
    .cpu_clk_en(link.cpu_clk_en), .resume(link.resume), .stab_busy(link.stab_busy),
    .xtal_running(xtal_running), .main_osc_en(main_osc_en),
    .int_hs_osc_en(int_hs_osc_en), .sub_osc_en(sub_osc_en));

  // 250 MHz bus clock
  always #2 hclk = ~hclk;

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      $display("BAD %s exp %h got %h", what, exp, got);
      errors++;
    end
  endtask : chk

  // one single word transfer; the slave alone decides the wait
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] wd);
    int k;
    k = 0;
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1 && k < 50) begin
      @(posedge hclk);
      k++;
    end
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1 && k < 100) begin
      @(posedge hclk);
      k++;
    end
    rd = hrdata;
  endtask : xfer

  // device register access through the access window, polled until idle
  task automatic dev(input logic w, input logic bop, input logic [15:0] a, input logic [7:0] d);
    int k;
    k = 0;
    xfer(1'b1, 32'h4, {6'h00, bop, w, d, a});
    rd = 32'h100;
    while (rd[8] !== 1'b0 && k < 50) begin
      xfer(1'b0, 32'h4, 32'h0);
      k++;
    end
  endtask : dev

  task automatic wait_clk(input int lim);
    n = 0;
    while (link.cpu_clk_en !== 1'b1 && n < lim) begin
      @(posedge hclk);
      n++;
    end
  endtask : wait_clk

  task automatic t_reset;
    xfer(1'b0, 32'h8, 32'h0);
    chk("stat", 32'h1, rd);
    xfer(1'b0, 32'hC, 32'h0);
    chk("unmapped", 32'h0, rd);
    dev(1'b0, 1'b0, sbc_pkg::SBC_ADDR_SELECT, 8'h00);
    chk("select rst", 32'h5, rd & 32'hFF);
    dev(1'b1, 1'b0, sbc_pkg::SBC_ADDR_STATUS, 8'hFF);
    dev(1'b0, 1'b0, sbc_pkg::SBC_ADDR_STATUS, 8'h00);
    chk("status ro", 32'h0, rd & 32'hFF);
    dev(1'b1, 1'b0, sbc_pkg::SBC_ADDR_SELECT, 8'hFB);
    dev(1'b0, 1'b0, sbc_pkg::SBC_ADDR_SELECT, 8'h00);
    chk("select wr", 32'h3, rd & 32'hFF);
    dev(1'b1, 1'b1, sbc_pkg::SBC_ADDR_SELECT, 8'h01);
    dev(1'b0, 1'b0, sbc_pkg::SBC_ADDR_SELECT, 8'h00);
    chk("select bitop", 32'h3, rd & 32'hFF);
    $display("test reset_regs done");
  endtask : t_reset

  task automatic t_halt(input logic ie);
    xfer(1'b1, 32'h0, {27'h0, ie, 4'h5});
    // the clock gate drops one cycle after the command pulse
    @(posedge hclk);
    xfer(1'b0, 32'h8, 32'h0);
    chk("stat halt", 32'h0, rd);
    chk("osc halt", 32'h7, {29'h0, main_osc_en, int_hs_osc_en, sub_osc_en});
    irq_in <= 1'b1;
    wait_clk(40);
    irq_in <= 1'b0;
    chk("halt wake", 32'h1, {31'h0, link.cpu_clk_en});
    @(posedge hclk);
    xfer(1'b0, 32'h8, 32'h0);
    chk("stat wake", {27'h0, ie, 4'h9}, rd);
    xfer(1'b0, 32'h0, 32'h0);
    chk("ctrl kept", {27'h0, ie, 4'h4}, rd);
    xfer(1'b1, 32'h8, 32'h0);
    $display("test halt done");
  endtask : t_halt

  // reset during halt: back to run with the clock on
  task automatic t_rst_halt;
    xfer(1'b1, 32'h0, 32'h1);
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    xfer(1'b0, 32'h8, 32'h0);
    chk("rst halt", 32'h1, rd);
    $display("test rst_halt done");
  endtask : t_rst_halt

  task automatic t_refuse;
    // the stop check uses the source already in force
    xfer(1'b1, 32'h0, 32'h8);
    xfer(1'b1, 32'h0, 32'hA);
    xfer(1'b0, 32'h8, 32'h0);
    chk("stop sub", 32'h5, rd);
    xfer(1'b1, 32'h8, 32'h0);
    xfer(1'b1, 32'h0, 32'h4);
    periph_main_busy <= 1'b1;
    xfer(1'b1, 32'h0, 32'h6);
    xfer(1'b0, 32'h8, 32'h0);
    chk("stop busy", 32'h5, rd);
    periph_main_busy <= 1'b0;
    xfer(1'b1, 32'h8, 32'h0);
    $display("test refuse done");
  endtask : t_refuse

  // internal fast clock: no wait, status capped at the selection
  task automatic t_stop_ihs;
    dev(1'b1, 1'b0, sbc_pkg::SBC_ADDR_SELECT, 8'h01);
    xfer(1'b1, 32'h0, 32'h2);
    repeat (4) @(posedge hclk);
    chk("osc stop", 32'h1, {29'h0, main_osc_en, int_hs_osc_en, sub_osc_en});
    dev(1'b0, 1'b0, sbc_pkg::SBC_ADDR_STATUS, 8'h00);
    chk("stat clear", 32'h0, rd & 32'hFF);
    irq_in <= 1'b1;
    wait_clk(40);
    irq_in <= 1'b0;
    chk("ihs wake", 32'h1, {31'h0, link.cpu_clk_en});
    repeat (9000) @(posedge hclk);
    dev(1'b0, 1'b0, sbc_pkg::SBC_ADDR_STATUS, 8'h00);
    chk("capped", 32'h10, rd & 32'hFF);
    xfer(1'b1, 32'h8, 32'h0);
    $display("test stop_ihs done");
  endtask : t_stop_ihs

  // crystal clock: start-up not counted, select locked, full wait
  task automatic t_stop_xtal;
    dev(1'b1, 1'b0, sbc_pkg::SBC_ADDR_SELECT, 8'h03);
    xtal_running <= 1'b0;
    xfer(1'b1, 32'h0, 32'h6);
    irq_in <= 1'b1;
    repeat (200) @(posedge hclk);
    dev(1'b1, 1'b0, sbc_pkg::SBC_ADDR_SELECT, 8'h05);
    xfer(1'b0, 32'h8, 32'h0);
    chk("stat wait", 32'h6, rd);
    dev(1'b0, 1'b0, sbc_pkg::SBC_ADDR_STATUS, 8'h00);
    chk("no count", 32'h0, rd & 32'hFF);
    dev(1'b0, 1'b0, sbc_pkg::SBC_ADDR_SELECT, 8'h00);
    chk("select kept", 32'h3, rd & 32'hFF);
    xtal_running <= 1'b1;
    wait_clk(16500);
    irq_in <= 1'b0;
    chk("wait len", 32'h1, {31'h0, n >= 16384 && n < 16430});
    @(posedge hclk);
    xfer(1'b0, 32'h8, 32'h0);
    chk("stat done", 32'hD, rd);
    dev(1'b0, 1'b0, sbc_pkg::SBC_ADDR_STATUS, 8'h00);
    chk("reached", 32'h1C, rd & 32'hFF);
    dev(1'b1, 1'b0, sbc_pkg::SBC_ADDR_MOC, 8'h80);
    dev(1'b0, 1'b0, sbc_pkg::SBC_ADDR_STATUS, 8'h00);
    chk("xtal stop clr", 32'h0, rd & 32'hFF);
    dev(1'b1, 1'b0, sbc_pkg::SBC_ADDR_MOC, 8'h00);
    $display("test stop_xtal done");
  endtask : t_stop_xtal

  task automatic complete_run;
    $display("tests %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : complete_run

  // main sequence
  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    irq_in = 1'b0;
    periph_main_busy = 1'b0;
    xtal_running = 1'b1;
    errors = 0;
    n_tests = 0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset;
    t_halt(1'b1);
    t_rst_halt;
    t_halt(1'b0);
    t_refuse;
    t_stop_ihs;
    t_stop_xtal;
    complete_run;
  end

  // watchdog: about four times the expected run
  initial begin
    #400000;
    errors++;
    complete_run;
  end
endmodule : tb_top
